// >>> tmpal_pkg.sv
// Shared constants and types of the temperature alarm and conversion block.
// Assumes a 100 MHz system clock; all counts below derive from that rate.
package tmpal_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_KHZ = 100_000;
  // Conversion time at 9-bit resolution, doubling per resolution step
  localparam int unsigned CONV_TIME_9B_MS = 30;
  localparam int unsigned CONV_9B_CYC = CONV_TIME_9B_MS * SYS_CLK_KHZ;
  // Shortest conversion period at 12-bit resolution
  localparam int unsigned PERIOD_BASE_MS = 250;
  localparam int unsigned PERIOD_BASE_CYC = PERIOD_BASE_MS * SYS_CLK_KHZ;
  // Period multipliers 1, 2, 4, 32 as shift counts
  localparam logic [2:0] PER_SHIFT_0 = 3'h0;
  localparam logic [2:0] PER_SHIFT_1 = 3'h1;
  localparam logic [2:0] PER_SHIFT_2 = 3'h2;
  localparam logic [2:0] PER_SHIFT_3 = 3'h5;
  localparam logic [1:0] RES_MAX = 2'h3;

  // ----------------------------------------------------------------
  // Thermostat mode codes and fault queue depths
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_COMP = 2'h0;
  localparam logic [1:0] MODE_INTR = 2'h1;
  localparam logic [1:0] MODE_ICMP = 2'h2;
  localparam logic [2:0] FAULTS_0 = 3'h1;
  localparam logic [2:0] FAULTS_1 = 3'h2;
  localparam logic [2:0] FAULTS_2 = 3'h4;
  localparam logic [2:0] FAULTS_3 = 3'h6;

  // ----------------------------------------------------------------
  // Register words and serial command fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] conversion_delay_bits;
    logic [1:0] resolution_bits;
    logic [1:0] fault_queue_bits;
    logic output_polarity_bit;
    logic [1:0] thermostat_mode_bits;
  } tmpal_cfg_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } tmpal_spi_t;

  localparam tmpal_cfg_t CFG_RESET = '{conversion_delay_bits: 2'h0, resolution_bits: 2'h3,
                                       fault_queue_bits: 2'h0, output_polarity_bit: 1'b0,
                                       thermostat_mode_bits: 2'h0};
  localparam logic [12:0] UPPER_RESET = 13'h0500;   // 80 C in 1/16 C steps
  localparam logic [12:0] LOWER_RESET = 13'h04b0;   // 75 C in 1/16 C steps
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  localparam logic [2:0] TAIL_TEMP = 3'h4;
  localparam logic [2:0] TAIL_CFG = 3'h2;
  localparam logic [2:0] TAIL_LOWER = 3'h4;
  localparam logic [2:0] TAIL_UPPER = 3'h6;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam int CMD_RW_BIT = 15;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] FIRST_UNDRIVEN = 4'he;

endpackage : tmpal_pkg

// >>> tmpal_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to sys_clk_i; one flop pair per bit.
`timescale 1ns/100ps

module tmpal_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Pins in, synchronised out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ----------------------------------------------------------------
  // Per-bit flop pair
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic meta;
      logic stable;
      // First flop feeds only the second one
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          meta <= RESET_VAL[b];
          stable <= RESET_VAL[b];
        end else begin
          meta <= async_i[b];
          stable <= meta;
        end
      end
      assign sync_o[b] = stable;
    end
  endgenerate

endmodule // tmpal_sync

// >>> tmpal_ctrl.sv
// Alarm, conversion scheduling and serial register port of a temperature sensor.
// Assumes an external converter presenting a 13-bit code on temp_code_i at sys_clk_i.
`timescale 1ns/100ps

// Summary of operation
// - Mode bits: 00 comparator, 01 interrupt, 10 interrupt-comparator, 11 reserved.
// - Comparator mode selected after reset.
// - Alert active low when polarity bit is 0, active high when 1.
// - Fault queue bits select 1, 2, 4 or 6 consecutive faults.
// - Fault queue bits reset to zero.
// - Comparator: alarm on temperature at or above upper limit for N conversions.
// - Comparator: alarm holds until below lower limit for N conversions.
// - Interrupt: alarm on upper limit for N conversions, cleared by completed read.
// - Interrupt: entering power-down clears the alarm.
// - Interrupt: after clearing, next alarm is below lower limit, alternating.
// - Interrupt-comparator: set as comparator, release needs low count then transaction.
// - Upper limit resets to 80 C, lower limit to 75 C.
// - Limits share result format; tails read 110 upper, 100 lower.
// - All 13 bits compared at every resolution.
// - Resolution bits pick 9 to 12 bits, 30 to 240 ms conversion.
// - Resolution resets to 12 bits.
// - Delay bits pick period 0.25, 0.5, 1 or 8 s at 12 bits.
// - Delay bits reset to zero, 0.25 s period at 12 bits.
// - Conversion time and period scale with resolution.
// - Input sampled on rising clock; output changes after falling clock.
// - Serial output released while chip select is high.
// - Low byte all ones enters power-down after current conversion; else wakes.
// - Result in top 13 bits, bit 2 one, two lowest undriven.
module tmpal_ctrl #(
  parameter logic [31:0] CONV_9B_CYC = 32'(tmpal_pkg::CONV_9B_CYC),
  parameter logic [31:0] PERIOD_BASE_CYC = 32'(tmpal_pkg::PERIOD_BASE_CYC)
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Serial port pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Alarm pin
  output logic alert_o,
  // Converter side
  input wire logic [12:0] temp_code_i,
  output logic conv_start_o,
  output logic conv_busy_o,
  output logic [1:0] resolution_o,
  output logic power_down_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  tmpal_pkg::tmpal_spi_t pins_s;
  tmpal_pkg::tmpal_spi_t pins_q;
  logic sck_rise, sck_fall, cs_fall, cs_act;

  tmpal_sync #(.W(3), .RESET_VAL(3'h4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({cs_n_i, sck_i, sdi_i}),
    .sync_o(pins_s)
  );

  // Edges seen on the stable copy only
  assign sck_rise = pins_s.sck & ~pins_q.sck;
  assign sck_fall = ~pins_s.sck & pins_q.sck;
  assign cs_fall = ~pins_s.cs_n & pins_q.cs_n;
  assign cs_act = ~pins_s.cs_n;

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  tmpal_pkg::tmpal_cfg_t cfg, next_cfg;
  logic [12:0] upper, next_upper, lower, next_lower, temp_q;
  logic [15:0] out_sr, next_out_sr, in_sr, next_in_sr, rd_word, cmd_word;
  logic [3:0] bit_cnt, next_bit_cnt, out_idx, next_out_idx;
  logic [1:0] ptr, next_ptr;
  logic phase_cmd, next_phase_cmd, reload, next_reload, sd_req, next_sd_req;
  logic read_done, unit_done;

  // Word presented for the current pointer
  always_comb begin
    unique case (ptr)
      tmpal_pkg::PTR_TEMP: rd_word = {temp_q, tmpal_pkg::TAIL_TEMP};
      tmpal_pkg::PTR_CFG: rd_word = {4'h0, cfg, tmpal_pkg::TAIL_CFG};
      tmpal_pkg::PTR_LOWER: rd_word = {lower, tmpal_pkg::TAIL_LOWER};
      default: rd_word = {upper, tmpal_pkg::TAIL_UPPER};
    endcase
  end

  assign cmd_word = {in_sr[14:0], pins_s.sdi};

  // Alternating 16-bit response and 16-bit command units
  always_comb begin
    next_cfg = cfg;
    next_upper = upper;
    next_lower = lower;
    next_out_sr = out_sr;
    next_in_sr = in_sr;
    next_bit_cnt = bit_cnt;
    next_out_idx = out_idx;
    next_ptr = ptr;
    next_phase_cmd = phase_cmd;
    next_reload = reload;
    next_sd_req = sd_req;
    read_done = 1'b0;
    unit_done = 1'b0;
    if (cs_fall) begin
      // First response bit valid as soon as chip select falls
      next_out_sr = rd_word;
      next_out_idx = 4'h0;
      next_bit_cnt = 4'h0;
      next_phase_cmd = 1'b0;
      next_reload = 1'b0;
    end else if (!cs_act) begin
      // Partial unit abandoned; pointer kept for next frame
      next_bit_cnt = 4'h0;
      next_phase_cmd = 1'b0;
      next_reload = 1'b0;
    end else if (sck_rise) begin
      if (phase_cmd) begin
        next_in_sr = cmd_word;
      end
      next_bit_cnt = 4'(bit_cnt + 4'h1);
      if (bit_cnt == tmpal_pkg::LAST_BIT) begin
        unit_done = 1'b1;
        next_phase_cmd = ~phase_cmd;
        if (!phase_cmd) begin
          read_done = 1'b1;
          next_ptr = tmpal_pkg::PTR_TEMP;
        end else begin
          next_reload = 1'b1;
          // power-down pattern, any other command wakes
          if (cmd_word[7:0] == tmpal_pkg::CMD_SHUTDOWN) begin
            next_sd_req = 1'b1;
          end else begin
            next_sd_req = 1'b0;
            // Tail decoded first: a negative limit also has its top bit set
            if (cmd_word[2:0] == tmpal_pkg::TAIL_CFG) begin
              next_cfg = cmd_word[11:3];
            end else if (cmd_word[2:0] == tmpal_pkg::TAIL_LOWER) begin
              next_lower = cmd_word[15:3];
            end else if (cmd_word[2:0] == tmpal_pkg::TAIL_UPPER) begin
              next_upper = cmd_word[15:3];
            end else if (cmd_word[tmpal_pkg::CMD_RW_BIT]) begin
              next_ptr = cmd_word[4:3];
            end
          end
        end
      end
    end else if (sck_fall) begin
      // output moves only after falling clock
      if (reload) begin
        next_out_sr = rd_word;
        next_out_idx = 4'h0;
        next_reload = 1'b0;
      end else if (!phase_cmd && bit_cnt != 4'h0) begin
        next_out_sr = {out_sr[14:0], 1'b0};
        next_out_idx = 4'(out_idx + 4'h1);
      end
    end
  end

  // Serial port registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_q <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
      cfg <= tmpal_pkg::CFG_RESET;
      upper <= tmpal_pkg::UPPER_RESET;
      lower <= tmpal_pkg::LOWER_RESET;
      out_sr <= 16'h0000;
      in_sr <= 16'h0000;
      bit_cnt <= 4'h0;
      out_idx <= 4'h0;
      ptr <= tmpal_pkg::PTR_TEMP;
      phase_cmd <= 1'b0;
      reload <= 1'b0;
      sd_req <= 1'b0;
    end else begin
      pins_q <= pins_s;
      cfg <= next_cfg;
      upper <= next_upper;
      lower <= next_lower;
      out_sr <= next_out_sr;
      in_sr <= next_in_sr;
      bit_cnt <= next_bit_cnt;
      out_idx <= next_out_idx;
      ptr <= next_ptr;
      phase_cmd <= next_phase_cmd;
      reload <= next_reload;
      sd_req <= next_sd_req;
    end
  end

  assign sdo_o = out_sr[15];
  // released when deselected and for the two lowest bits
  assign sdo_oe_o = cs_act & ~phase_cmd & ~reload & (out_idx < tmpal_pkg::FIRST_UNDRIVEN);

  // ----------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CV_CONVERT, CV_IDLE, CV_SHUT} tmpal_cv_t;
  tmpal_cv_t cv_state, next_cv_state;
  logic [31:0] timer, next_timer, conv_cyc, period_cyc;
  logic [12:0] next_temp_q, code_masked;
  logic [2:0] per_shift;
  logic conv_done, next_start;

  // time and period scale with resolution
  always_comb begin
    unique case (cfg.conversion_delay_bits)
      2'h0: per_shift = tmpal_pkg::PER_SHIFT_0;
      2'h1: per_shift = tmpal_pkg::PER_SHIFT_1;
      2'h2: per_shift = tmpal_pkg::PER_SHIFT_2;
      default: per_shift = tmpal_pkg::PER_SHIFT_3;
    endcase
    conv_cyc = CONV_9B_CYC << cfg.resolution_bits;
    period_cyc = (PERIOD_BASE_CYC << per_shift) >> 2'(tmpal_pkg::RES_MAX - cfg.resolution_bits);
    // Unused result bits read as zero at lower resolution
    code_masked = temp_code_i & ~(13'(13'h7 >> cfg.resolution_bits));
  end

  // Conversion, idle remainder and power-down
  always_comb begin
    next_cv_state = cv_state;
    next_timer = 32'(timer + 32'h1);
    next_temp_q = temp_q;
    next_start = 1'b0;
    conv_done = 1'b0;
    unique case (cv_state)
      CV_CONVERT: begin
        if (timer >= 32'(conv_cyc - 32'h1)) begin
          conv_done = 1'b1;
          next_temp_q = code_masked;
          // finish the running conversion before power-down
          if (sd_req) begin
            next_cv_state = CV_SHUT;
          end else if (period_cyc <= conv_cyc) begin
            next_timer = 32'h0;
            next_start = 1'b1;
          end else begin
            next_cv_state = CV_IDLE;
          end
        end
      end
      CV_IDLE: begin
        if (sd_req) begin
          next_cv_state = CV_SHUT;
        end else if (timer >= 32'(period_cyc - 32'h1)) begin
          next_cv_state = CV_CONVERT;
          next_timer = 32'h0;
          next_start = 1'b1;
        end
      end
      CV_SHUT: begin
        next_timer = 32'h0;
        if (!sd_req) begin
          next_cv_state = CV_CONVERT;
          next_start = 1'b1;
        end
      end
      default: next_cv_state = CV_CONVERT;
    endcase
  end

  // Scheduler registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cv_state <= CV_CONVERT;
      timer <= 32'h0;
      temp_q <= tmpal_pkg::TEMP_RESET;
      conv_start_o <= 1'b0;
    end else begin
      cv_state <= next_cv_state;
      timer <= next_timer;
      temp_q <= next_temp_q;
      conv_start_o <= next_start;
    end
  end

  assign conv_busy_o = (cv_state == CV_CONVERT);
  assign power_down_o = (cv_state == CV_SHUT);
  assign resolution_o = cfg.resolution_bits;

  // ----------------------------------------------------------------
  // Alarm filter
  // ----------------------------------------------------------------
  logic active, next_active, look_low, next_look_low, rel_pend, next_rel_pend;
  logic [2:0] fault_cnt, next_fault_cnt, need;
  logic hot, cold, watch_low, cond, fire, sd_enter;

  always_comb begin
    unique case (cfg.fault_queue_bits)
      2'h0: need = tmpal_pkg::FAULTS_0;
      2'h1: need = tmpal_pkg::FAULTS_1;
      2'h2: need = tmpal_pkg::FAULTS_2;
      default: need = tmpal_pkg::FAULTS_3;
    endcase
  end

  assign hot = $signed(code_masked) >= $signed(upper);
  assign cold = $signed(code_masked) < $signed(lower);
  assign watch_low = (cfg.thermostat_mode_bits == tmpal_pkg::MODE_INTR) ? look_low : active;
  assign cond = watch_low ? cold : hot;
  assign fire = conv_done & cond & (3'(fault_cnt + 3'h1) >= need);
  assign sd_enter = next_sd_req & ~sd_req;

  // Clears first, so a same-cycle fault event wins
  always_comb begin
    next_active = active;
    next_look_low = look_low;
    next_rel_pend = rel_pend;
    next_fault_cnt = fault_cnt;
    if (conv_done) begin
      next_fault_cnt = (cond && !fire) ? 3'(fault_cnt + 3'h1) : 3'h0;
    end
    unique case (cfg.thermostat_mode_bits)
      tmpal_pkg::MODE_INTR: begin
        // cleared by completed read or power-down
        if (read_done || sd_enter) begin
          next_active = 1'b0;
        end
        // alternate between upper and lower trip
        if (fire) begin
          next_active = 1'b1;
          next_look_low = ~look_low;
        end
      end
      tmpal_pkg::MODE_ICMP: begin
        // release after low count plus a later transaction
        if (unit_done && rel_pend) begin
          next_active = 1'b0;
          next_rel_pend = 1'b0;
        end
        if (fire && !active) begin
          next_active = 1'b1;
          next_rel_pend = 1'b0;
        end else if (fire) begin
          next_rel_pend = 1'b1;
        end
      end
      default: begin
        if (fire) begin
          next_active = ~active;
        end
      end
    endcase
  end

  // Alarm registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active <= 1'b0;
      look_low <= 1'b0;
      rel_pend <= 1'b0;
      fault_cnt <= 3'h0;
      alert_o <= 1'b1;
    end else begin
      active <= next_active;
      look_low <= next_look_low;
      rel_pend <= next_rel_pend;
      fault_cnt <= next_fault_cnt;
      alert_o <= cfg.output_polarity_bit ? active : ~active;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_ALERT_POLARITY: assert property (
    ##1 alert_o == ($past(cfg.output_polarity_bit) ? $past(active) : !$past(active)))
    else $error("alert pin does not follow polarity");
  AST_COMP_SET: assert property (
    conv_done && cfg.thermostat_mode_bits == tmpal_pkg::MODE_COMP && !active && hot
      && 3'(fault_cnt + 3'h1) >= need |=> active)
    else $error("comparator alarm not raised");
  AST_COMP_CLEAR: assert property (
    conv_done && cfg.thermostat_mode_bits == tmpal_pkg::MODE_COMP && active && !cold
      |=> active)
    else $error("comparator alarm dropped while not cold");
  AST_INTR_READ_CLEAR: assert property (
    cfg.thermostat_mode_bits == tmpal_pkg::MODE_INTR && read_done && !fire |=> !active)
    else $error("interrupt alarm not cleared by read");
  AST_INTR_SD_CLEAR: assert property (
    cfg.thermostat_mode_bits == tmpal_pkg::MODE_INTR && sd_enter && !fire |=> !active)
    else $error("interrupt alarm not cleared by power-down");
  AST_ICMP_HOLD: assert property (
    cfg.thermostat_mode_bits == tmpal_pkg::MODE_ICMP && active && !rel_pend |=> active)
    else $error("interrupt-comparator alarm released early");
  AST_SDO_RELEASE: assert property (
    cs_n_i [*3] |-> !sdo_oe_o)
    else $error("output driven while deselected");
  AST_SDO_FALL_ONLY: assert property (
    $changed(out_sr) |-> $past(sck_fall) || $past(cs_fall))
    else $error("output changed outside a falling edge");
  AST_FAULT_RESET: assert property (
    conv_done && !cond |=> fault_cnt == 3'h0)
    else $error("fault counter kept after a non-fault");
  AST_SHUT_NO_START: assert property (
    sd_req && cv_state != CV_CONVERT |=> !conv_start_o ##1 !conv_busy_o || !sd_req)
    else $error("conversion started in power-down");

  COV_COMP_ALARM: cover property (cfg.thermostat_mode_bits == tmpal_pkg::MODE_COMP ##0 $rose(active));
  COV_INTR_READ: cover property (cfg.thermostat_mode_bits == tmpal_pkg::MODE_INTR && active
    ##0 read_done ##1 !active);
  COV_SHUTDOWN: cover property (cv_state == CV_SHUT);
  COV_WRITE: cover property (unit_done && phase_cmd);

endmodule // tmpal_ctrl

// >>> tmpal_host.sv
// Host serial controller model: response, command, response in one frame.
// Assumes the bench clock; pins change just after its rising edge.
`timescale 1ns/100ps

module tmpal_host (
  // Clock
  input wire logic sys_clk_i,
  // Serial pins
  output tmpal_pkg::tmpal_spi_t spi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // Deselected with the link clock parked low
  initial spi_o = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};

  // Half of the 160 ns link clock
  task automatic half();
    repeat (8) @(posedge sys_clk_i);
  endtask

  // Clock stands still outside the frame
  task automatic frame(input logic [15:0] c, output logic [15:0] r0, output logic [15:0] r1);
    logic [47:0] sh;
    logic b;
    b = 1'b0;
    spi_o.cs_n <= 1'b0;
    for (int i = 47; i >= 0; i--) begin
      // data set up ahead of rising
      spi_o.sdi <= (i < 32 && i >= 16) ? c[i-16] : ~spi_o.sdi;
      half();
      spi_o.sck <= 1'b1;
      // A released line shows the inverse of its last bit
      b = sdo_oe_i ? sdo_i : ~b;
      sh = {sh[46:0], b};
      half();
      spi_o.sck <= 1'b0;
    end
    half();
    spi_o.cs_n <= 1'b1;
    r0 = sh[47:32];
    r1 = sh[15:0];
  endtask
endmodule // tmpal_host

// >>> temp_alarm_and_conversion_ctrl_tb_top.sv
// Self-checking bench of the temperature alarm and conversion controller.
// Assumes tmpal_pkg, tmpal_ctrl and tmpal_host are compiled before it.
`timescale 1ns/100ps

module temp_alarm_and_conversion_ctrl_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [12:0] temp_code_i = 13'h0000;
  tmpal_pkg::tmpal_spi_t spi;
  logic sdo_o, sdo_oe_o, alert_o, conv_start_o, conv_busy_o, power_down_o;
  logic [1:0] resolution_o;
  logic [15:0] r0, r1, w;
  logic [12:0] v;
  int errors = 0, n_tests = 0, cyc = 0, seed = 32'h659a, hi, per;

  // Clock; short counts keep a conversion a few hundred cycles
  always #5 sys_clk_i = ~sys_clk_i;
  tmpal_ctrl #(.CONV_9B_CYC(32'd40), .PERIOD_BASE_CYC(32'd400)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cs_n_i(spi.cs_n), .sck_i(spi.sck),
    .sdi_i(spi.sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .alert_o(alert_o),
    .temp_code_i(temp_code_i), .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
    .resolution_o(resolution_o), .power_down_o(power_down_o));
  tmpal_host host (.sys_clk_i(sys_clk_i), .spi_o(spi), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

  // Verdict and end of run
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Lowest two bits are undriven, so they are masked
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if ((g & 16'hfffc) !== (e & 16'hfffc)) begin
      errors++;
      $display("unexpected %0t word %h not %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t bit %b not %b", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    n_tests++;
    if (g != e) begin
      errors++;
      $display("unexpected %0t count %0d not %0d", $time, g, e);
    end
  endtask

  // Expected words and periods
  function automatic logic [15:0] cfg_w(input logic [1:0] d, r, f, input logic p,
                                        input logic [1:0] m);
    return {4'h0, d, r, f, p, m, 3'h2};
  endfunction
  function automatic int exp_per(input logic [1:0] r, input logic [1:0] d);
    int m [4] = '{1, 2, 4, 32};
    return (400 * m[d]) >> (3 - r);
  endfunction

  // Frame, then align to a conversion end so temperature steps land cleanly
  task automatic fr(input logic [15:0] c);
    host.frame(c, r0, r1);
    repeat (6) @(negedge sys_clk_i);
    chk_b(sdo_oe_o, 1'b0); // released once deselected
    conv(1);
  endtask
  task automatic rd(input logic [1:0] p);
    fr(16'h8000 | {11'h0, p, 3'h0});
  endtask
  task automatic wc(input logic [1:0] d, r, f, input logic p, input logic [1:0] m);
    w = cfg_w(d, r, f, p, m);
    fr(w);
    rd(tmpal_pkg::PTR_CFG);
    chk_w(r1, w); // config readback
  endtask
  task automatic conv(input int n);
    repeat (n) @(negedge conv_busy_o);
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic gc(input logic [12:0] t, input int n, input logic e);
    @(posedge sys_clk_i);
    temp_code_i <= t;
    conv(n);
    chk_b(alert_o, e);
  endtask
  // Busy length and fall-to-fall period
  task automatic meas();
    int lo;
    lo = 0;
    hi = 0;
    @(negedge conv_busy_o);
    while (conv_busy_o !== 1'b1 && lo < 20000) begin
      @(negedge sys_clk_i);
      lo++;
    end
    chk_b(conv_start_o, 1'b1); // start pulse opens the conversion
    while (conv_busy_o === 1'b1 && hi < 20000) begin
      @(negedge sys_clk_i);
      hi++;
    end
    per = lo + hi - 1;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rd(tmpal_pkg::PTR_CFG);
    chk_w(r0, 16'h0004); // zero before a result
    chk_w(r1, 16'h0302); // config defaults
    rd(2'h3);
    chk_w(r1, 16'h2806); // upper default
    rd(tmpal_pkg::PTR_LOWER);
    chk_w(r1, 16'h2584); // lower default
    chk_b(alert_o, 1'b1); // inactive reads high
    gc(13'h0500, 1, 1'b0); // equal to upper raises
    gc(13'h04b0, 2, 1'b0); // equal to lower holds
    gc(13'h04af, 1, 1'b1); // below lower releases
    $display("comparator done");
    wc(2'h0, 2'h3, 2'h3, 1'b0, 2'h0);
    gc(13'h0600, 5, 1'b1); // five faults fall short
    gc(13'h0600, 1, 1'b0); // sixth raises
    gc(13'h0100, 5, 1'b0); // five cool ones held
    gc(13'h0600, 1, 1'b0); // a warm one restarts the count
    gc(13'h0100, 5, 1'b0); // still held
    gc(13'h0100, 1, 1'b1); // sixth releases
    wc(2'h0, 2'h3, 2'h0, 1'b1, 2'h0);
    chk_b(alert_o, 1'b0); // inverted when inactive
    gc(13'h0600, 1, 1'b1); // inverted when active
    gc(13'h0100, 1, 1'b0); // back to inactive
    $display("queue and polarity done");
    wc(2'h0, 2'h3, 2'h0, 1'b0, tmpal_pkg::MODE_INTR);
    gc(13'h0600, 2, 1'b0); // raised and held
    rd(tmpal_pkg::PTR_TEMP);
    chk_w(r1, 16'h3004); // result layout
    chk_b(alert_o, 1'b1); // read clears, no new upper event
    gc(13'h0100, 1, 1'b0); // below lower raises
    rd(tmpal_pkg::PTR_TEMP);
    chk_b(alert_o, 1'b1); // read clears again
    gc(13'h0600, 1, 1'b0); // upper rearmed
    host.frame(16'h00ff, r0, r1); // power-down request
    for (int i = 0; i < 1000 && power_down_o !== 1'b1; i++) @(negedge sys_clk_i);
    chk_b(power_down_o, 1'b1); // entered after the conversion
    chk_b(conv_busy_o, 1'b0); // no further conversion
    chk_b(alert_o, 1'b1); // cleared
    @(posedge sys_clk_i);
    temp_code_i <= 13'h0100;
    wc(2'h0, 2'h3, 2'h0, 1'b0, tmpal_pkg::MODE_ICMP);
    chk_b(power_down_o, 1'b0); // another command wakes
    gc(13'h0600, 1, 1'b0); // raised as comparator
    gc(13'h0100, 2, 1'b0); // waits for a transaction
    rd(tmpal_pkg::PTR_TEMP);
    chk_b(alert_o, 1'b1); // released by it
    $display("interrupt modes done");
    for (int k = 0; k < 4; k++) begin
      v = 13'($random(seed));
      fr({v, k[0] ? 3'h6 : 3'h4});
      rd(k[0] ? 2'h3 : tmpal_pkg::PTR_LOWER);
      chk_w(r1, {v, k[0] ? 3'h6 : 3'h4}); // limit readback
    end
    for (int k = 0; k < 4; k++) begin
      wc(2'(k + 3), 2'(k), 2'h0, 1'b0, 2'h0);
      meas();
      meas();
      chk_n(hi, 40 << k); // conversion time
      chk_n(per, exp_per(2'(k), 2'(k + 3))); // period
      chk_w({resolution_o, 14'h0}, {2'(k), 14'h0}); // resolution out
    end
    $display("timing done");
    wc(2'h0, 2'h0, 2'h0, 1'b0, 2'h0);
    fr({13'h0501, 3'h6});
    fr({13'h0500, 3'h4});
    gc(13'h0507, 2, 1'b1); // masked code under upper
    gc(13'h050f, 1, 1'b0); // limit low bits still count
    $display("limit bits done");
    end_sim();
  end
endmodule // temp_alarm_and_conversion_ctrl_tb_top
